// ### inc/rst_ctrl_pkg.sv
// Behaviour
// - Six reset origins are accepted
// - Power-on resets core, peripherals and test port
// - Pin reset spares test port state
// - Set-then-clear peripheral bit resets that peripheral
// - Peripheral reset drives all its domain resets
// - Sticky cause flag set for each reset
// - Pin reset clears all other cause flags
// - Pin and power-on use main oscillator
// - Power-on holds reset until detector inactive
// - Power-on detector only on first power-up
// - Release fetches stack pointer, counter, instruction
// - Brown-out reset disabled until software enables
// - Brown-out resets when enable set, or after resample when resample bit set
// - Resample after delay, drop if gone
// - Persistent brown-out asserts then releases reset
// - Brown-out condition cleared after 500 us
// - System request resets core, peripherals, not port
// - Second watchdog expiry resets when enabled
// - Regulator fault resets only when enabled
package rst_ctrl_pkg;
   // ==========================================
   // Register map (word addresses, one per 32-bit register)
   localparam logic [3:0] ADDR_CAUSE = 4'h0;
   localparam logic [3:0] ADDR_SUPPLY = 4'h1;
   localparam logic [3:0] ADDR_PERIPH = 4'h2;
   localparam logic [3:0] ADDR_CORE = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   // Cause flag positions
   localparam int CAUSE_PIN = 0;
   localparam int CAUSE_POR = 1;
   localparam int CAUSE_BOR = 2;
   localparam int CAUSE_WDT = 3;
   localparam int CAUSE_SW = 4;
   localparam int CAUSE_REG = 5;
   localparam int NUM_CAUSE = 6;
   // Supply control fields
   localparam int SUP_BOR_EN = 0;
   localparam int SUP_RESAMP = 1;
   localparam int SUP_REG_EN = 2;
   localparam int SUP_DLY_LSB = 8;
   localparam int DLY_W = 16;
   localparam logic [31:0] SUPPLY_RESET = 32'h0000_0000;
   localparam int CORE_SYSREQ = 2;
   localparam int NUM_PERIPH = 32;
   // ==========================================
   // Timing
   localparam int CLK_MHZ = 50;
   localparam int BOR_HOLD_US = 500;
   localparam int BOR_HOLD_CYC = BOR_HOLD_US * CLK_MHZ;
   localparam logic [3:0] RST_PULSE_CYC = 4'h8;
   localparam logic [1:0] BOOT_STEPS = 2'h3;
   typedef enum logic [2:0]
   {
      ST_RUN = 3'b000,
      ST_HOLD = 3'b001,
      ST_SP = 3'b010,
      ST_PC = 3'b011,
      ST_INSN = 3'b100
   } seq_state_t;
endpackage

// ### rtl/reset_source_controller.sv
`timescale 1ns/1ps
module reset_source_controller #(
   parameter int BOR_HOLD = rst_ctrl_pkg::BOR_HOLD_CYC // Brown-out hold cycles
)(
   input wire logic ref_clk, // 50 MHz main oscillator clock
   input wire logic rstn, // Async reset
   input wire logic clk_en, // Freezes all state when low
   input wire logic ext_rst_n, // External reset pin, low active
   input wire logic por_det, // Power-on detector active
   input wire logic bor_det, // Brown-out detector level
   input wire logic wdt_expire2, // Second watchdog expiry, pulse
   input wire logic wdt_rst_en, // Watchdog reset enabled
   input wire logic reg_fault, // Regulator unregulated
   input wire logic [3:0] avs_address, // Word address
   input wire logic avs_read, // Read strobe
   input wire logic avs_write, // Write strobe
   input wire logic [31:0] avs_writedata, // Write data
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   output logic core_rst, // Core reset
   output logic tap_rst, // Test port controller reset
   output logic tap_pin_cfg_rst, // Test port pin config reset
   output logic periph_rst_all, // Global peripheral reset
   output logic [31:0] periph_rst, // Per-peripheral reset
   output logic [1:0] boot_fetch, // 1 SP, 2 PC, 3 instruction
   output logic core_run // Core executing
);
   // ==========================================
   // Source decode
   logic [31:0] supply_q, periph_q, prev_periph_q;
   logic [5:0] cause_q;
   logic [31:0] bor_cnt_q;
   logic [15:0] rs_cnt_q;
   logic bor_cond_q, rs_busy_q, ack_q, sysreq_q, por_seen_q;
   rst_ctrl_pkg::seq_state_t st_q, st_d;
   wire por_ev = por_det && !por_seen_q;
   wire pin_ev = !ext_rst_n;
   wire bor_en = supply_q[rst_ctrl_pkg::SUP_BOR_EN];
   wire bor_new = bor_det && !bor_cond_q;
   wire bor_ev = bor_en ? bor_new : (rs_busy_q && rs_cnt_q == 16'h0 && bor_det);
   wire wdt_ev = wdt_expire2 && wdt_rst_en;
   wire reg_ev = reg_fault && supply_q[rst_ctrl_pkg::SUP_REG_EN];
   wire sw_ev = sysreq_q;
   wire any_int = pin_ev || por_det || bor_ev || wdt_ev || reg_ev || sw_ev;
   wire acc = (avs_read || avs_write) && !ack_q;
   // Write lands on the edge where the master sees waitrequest low
   wire wr = avs_write && ack_q;
   wire [5:0] ev_vec = {reg_ev, sw_ev, wdt_ev, bor_ev, por_ev, pin_ev};
   // Pulse on falling edge of a soft bit
   wire [31:0] soft_pulse = prev_periph_q & ~periph_q;

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         rst_ctrl_pkg::ST_RUN: if (any_int) st_d = rst_ctrl_pkg::ST_HOLD;
         rst_ctrl_pkg::ST_HOLD: if (!any_int && !pin_ev && !por_det) st_d = rst_ctrl_pkg::ST_SP;
         rst_ctrl_pkg::ST_SP: st_d = rst_ctrl_pkg::ST_PC;
         rst_ctrl_pkg::ST_PC: st_d = rst_ctrl_pkg::ST_INSN;
         rst_ctrl_pkg::ST_INSN: st_d = rst_ctrl_pkg::ST_RUN;
         default: st_d = rst_ctrl_pkg::ST_RUN;
      endcase
      if (any_int) st_d = rst_ctrl_pkg::ST_HOLD;
   end

   // ==========================================
   // Registers and sequencing
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         supply_q <= rst_ctrl_pkg::SUPPLY_RESET;
         periph_q <= 32'h0000_0000;
         prev_periph_q <= 32'h0000_0000;
         cause_q <= 6'h00;
         bor_cond_q <= 1'b0;
         bor_cnt_q <= 32'h0000_0000;
         rs_busy_q <= 1'b0;
         rs_cnt_q <= 16'h0000;
         ack_q <= 1'b0;
         sysreq_q <= 1'b0;
         por_seen_q <= 1'b0;
         st_q <= rst_ctrl_pkg::ST_HOLD;
      end
      else if (clk_en)
      begin
         st_q <= st_d;
         ack_q <= acc;
         prev_periph_q <= periph_q;
         if (por_det) por_seen_q <= 1'b1;
         sysreq_q <= wr && avs_address == rst_ctrl_pkg::ADDR_CORE && avs_writedata[rst_ctrl_pkg::CORE_SYSREQ];
         // Sticky causes; pin wipes the rest
         if (pin_ev) cause_q <= 6'h01;
         else if (wr && avs_address == rst_ctrl_pkg::ADDR_CAUSE) cause_q <= (cause_q & ~avs_writedata[5:0]) | ev_vec;
         else cause_q <= cause_q | ev_vec;
         if (wr && avs_address == rst_ctrl_pkg::ADDR_SUPPLY) supply_q <= avs_writedata;
         if (wr && avs_address == rst_ctrl_pkg::ADDR_PERIPH) periph_q <= avs_writedata;
         // Brown-out latch, held 500 us to stop re-trigger
         if (bor_cond_q)
         begin
            if (bor_cnt_q >= 32'(BOR_HOLD - 1)) bor_cond_q <= 1'b0;
            bor_cnt_q <= bor_cnt_q + 32'h1;
         end
         else if (bor_det)
         begin
            bor_cond_q <= 1'b1;
            bor_cnt_q <= 32'h0;
         end
         // Resample window
         if (bor_new && !bor_en && supply_q[rst_ctrl_pkg::SUP_RESAMP])
         begin
            rs_busy_q <= 1'b1;
            rs_cnt_q <= supply_q[rst_ctrl_pkg::SUP_DLY_LSB +: rst_ctrl_pkg::DLY_W];
         end
         else if (rs_busy_q)
         begin
            if (rs_cnt_q == 16'h0) rs_busy_q <= 1'b0;
            else rs_cnt_q <= rs_cnt_q - 16'h1;
         end
      end
   end

   // ==========================================
   // Registered outputs
   logic [31:0] rd_d;
   always_comb
   begin
      case (avs_address)
         rst_ctrl_pkg::ADDR_CAUSE: rd_d = {26'h0, cause_q};
         rst_ctrl_pkg::ADDR_SUPPLY: rd_d = supply_q;
         rst_ctrl_pkg::ADDR_PERIPH: rd_d = periph_q;
         rst_ctrl_pkg::ADDR_STATUS: rd_d = {28'h0, rs_busy_q, bor_cond_q, st_q == rst_ctrl_pkg::ST_RUN, por_seen_q};
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         avs_readdata <= 32'h0000_0000;
         avs_waitrequest <= 1'b1;
         core_rst <= 1'b1;
         tap_rst <= 1'b1;
         tap_pin_cfg_rst <= 1'b1;
         periph_rst_all <= 1'b1;
         periph_rst <= 32'hFFFF_FFFF;
         boot_fetch <= 2'h0;
         core_run <= 1'b0;
      end
      else if (clk_en)
      begin
         avs_readdata <= rd_d;
         avs_waitrequest <= !acc;
         core_rst <= st_d == rst_ctrl_pkg::ST_HOLD;
         tap_rst <= por_det;
         tap_pin_cfg_rst <= por_det || pin_ev;
         periph_rst_all <= st_d == rst_ctrl_pkg::ST_HOLD;
         periph_rst <= soft_pulse | {32{st_d == rst_ctrl_pkg::ST_HOLD}};
         boot_fetch <= (st_d == rst_ctrl_pkg::ST_SP) ? 2'h1 : (st_d == rst_ctrl_pkg::ST_PC) ? 2'h2 :
                       (st_d == rst_ctrl_pkg::ST_INSN) ? 2'h3 : 2'h0;
         core_run <= st_d == rst_ctrl_pkg::ST_RUN;
      end
   end

   // ==========================================
   // Checks
   // Every source except brown-out, so brown-out gating can be seen alone
   wire other_src = pin_ev || por_det || wdt_ev || reg_ev || sw_ev;
   wire boot_start = clk_en && st_q == rst_ctrl_pkg::ST_HOLD && st_d == rst_ctrl_pkg::ST_SP;
   sequence s_clean;
      (clk_en && !any_int) [*3];
   endsequence
   a_boot_order: assert property (@(posedge ref_clk) disable iff (!rstn || !clk_en)
      $rose(boot_fetch == 2'h1) && $past(core_rst) |-> ##1 (boot_fetch == 2'h2 || core_rst))
      else $error("boot fetch order broken");
   a_boot_seq: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_start ##1 s_clean |=> core_run)
      else $error("core did not start");
   a_pin_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && pin_ev |=> cause_q == 6'h01)
      else $error("pin reset left other causes");
   a_cause_sticky: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && !pin_ev && !(avs_write && avs_address == rst_ctrl_pkg::ADDR_CAUSE) |=> (cause_q & $past(cause_q)) == $past(cause_q))
      else $error("cause flag lost");
   a_tap_spared: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && !por_det |=> !tap_rst)
      else $error("test port reset without power-on");
   a_bor_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && st_q == rst_ctrl_pkg::ST_RUN && !bor_en && !rs_busy_q && bor_det && !other_src |=> !core_rst)
      else $error("brown-out reset while disabled");
   a_reg_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && st_q == rst_ctrl_pkg::ST_RUN && !supply_q[rst_ctrl_pkg::SUP_REG_EN] && !pin_ev && !por_det
      && !bor_ev && !wdt_ev && !sw_ev |=> !core_rst)
      else $error("regulator reset while disabled");
   a_soft_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && core_run && $fell(periph_q[0]) |=> periph_rst[0] && !core_rst)
      else $error("peripheral reset missing");
   a_sysreq_rst: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && sysreq_q |=> core_rst && periph_rst_all)
      else $error("system request ignored");

   // ==========================================
   // Domain checks per source

   a_por_domains: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && por_det |=> core_rst && tap_rst && periph_rst_all)
      else $error("power-on missed a domain");

   a_pin_domains: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && pin_ev |=> core_rst && periph_rst_all && tap_pin_cfg_rst)
      else $error("pin reset missed a domain");

   a_pin_tap_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && pin_ev && !por_det |=> !tap_rst)
      else $error("pin reset hit test port state");

   a_int_tap: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && (wdt_ev || reg_ev || bor_ev || sw_ev) && !por_det && !pin_ev |=> !tap_rst && !tap_pin_cfg_rst)
      else $error("internal reset hit test port");

   a_wdt_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && wdt_ev |=> core_rst && periph_rst_all)
      else $error("watchdog reset missing");

   a_reg_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && reg_ev |=> core_rst && periph_rst_all)
      else $error("regulator reset missing");

   a_no_spurious: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && st_q == rst_ctrl_pkg::ST_RUN && !any_int |=> !core_rst && !periph_rst_all)
      else $error("reset without a source");

   // ==========================================
   // Brown-out path

   a_bor_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && bor_ev |=> core_rst && periph_rst_all)
      else $error("brown-out reset missing");

   a_resample_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && st_q == rst_ctrl_pkg::ST_RUN && rs_busy_q && rs_cnt_q == 16'h0 && !bor_det && !bor_en
      && !other_src |=> !core_rst)
      else $error("noise brown-out caused reset");

   a_resample_fire: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && rs_busy_q && rs_cnt_q == 16'h0 && bor_det && !bor_en |=> core_rst)
      else $error("persistent brown-out ignored");

   // Latch must outlive the hold so a second event is not logged early
   a_bor_latched: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && bor_cond_q && bor_cnt_q < 32'(BOR_HOLD - 1) |=> bor_cond_q)
      else $error("brown-out latch dropped early");

   a_bor_release: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && bor_cond_q && bor_cnt_q >= 32'(BOR_HOLD - 1) |=> !bor_cond_q)
      else $error("brown-out latch stuck");

   // ==========================================
   // Peripheral soft resets

   a_soft_core_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && (|soft_pulse) && st_q == rst_ctrl_pkg::ST_RUN && !any_int |=> !core_rst && !tap_rst)
      else $error("soft reset hit the core");

   a_soft_all_dom: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && (|soft_pulse) |=> (periph_rst & $past(soft_pulse)) == $past(soft_pulse))
      else $error("soft reset bit not driven");

   // ==========================================
   // Cause flags and boot

   a_cause_set: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && !pin_ev |=> (cause_q & $past(ev_vec)) == $past(ev_vec))
      else $error("cause flag not set");

   a_sysreq_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && sysreq_q && !pin_ev |=> cause_q[rst_ctrl_pkg::CAUSE_SW])
      else $error("system request not recorded");

   a_por_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && por_det |=> !core_run && boot_fetch == 2'h0)
      else $error("core left reset during power-on");

   a_pin_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && pin_ev |=> !core_run)
      else $error("core ran with pin low");

   a_run_out: assert property (@(posedge ref_clk) disable iff (!rstn)
      core_run |-> boot_fetch == 2'h0)
      else $error("fetch phase while running");

   a_boot_walk: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_start ##1 s_clean |-> $past(boot_fetch, 2) == 2'h1 && $past(boot_fetch) == 2'h2 && boot_fetch == 2'h3)
      else $error("boot fetch steps out of order");

   // ==========================================
   // Bus and clock enable

   a_wait_one: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");

   // Held state must not drift while the enable is low
   a_clk_freeze: assert property (@(posedge ref_clk) disable iff (!rstn)
      !clk_en |=> $stable(st_q) && $stable(cause_q) && $stable(supply_q))
      else $error("state moved while frozen");
endmodule // reset_source_controller

// ### tb/board_side_model.sv
`timescale 1ns/1ps
// ====
// Reset button and power-on detector on the board
module board_side_model #(
   parameter int T_MIN = 6 // Minimum pin pulse width
)(
   input wire logic ref_clk, // Clock
   input wire logic press, // Ask for one pin pulse
   output logic ext_rst_n, // Pin, pulled up when idle
   output logic por_det // Power-on detector
);
   initial
   begin
      ext_rst_n = 1'h1;
      por_det = 1'h1;
      repeat (12) @(posedge ref_clk);
      por_det <= 1'h0; // Never again while powered
      forever
      begin
         @(posedge ref_clk);
         if (press === 1'h1)
         begin
            ext_rst_n <= 1'h0;
            repeat (T_MIN) @(posedge ref_clk);
            ext_rst_n <= 1'h1;
         end
      end
   end
endmodule // board_side_model

// ### tb/reset_source_controller_bench.sv
`timescale 1ns/1ps
module reset_source_controller_bench;
   logic rstn;
   logic ref_clk = 1'h0, clk_en = 1'h1, press = 1'h0, clr = 1'h0, por_bad = 1'h0;
   logic bor_det = 1'h0, wdt_expire2 = 1'h0, wdt_rst_en = 1'h0, reg_fault = 1'h0;
   logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest, core_rst, tap_rst, tap_pin_cfg_rst;
   logic periph_rst_all, core_run;
   logic [3:0] avs_address = 4'h0, seen = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, periph_rst, seen_p = 32'h0, q;
   logic [1:0] boot_fetch;
   logic [1:0] bq[$];
   wire ext_rst_n, por_det;
   int miscompares = 0, checked = 0, cause_m, k, d;
   board_side_model bsm (.ref_clk(ref_clk), .press(press), .ext_rst_n(ext_rst_n), .por_det(por_det));
   reset_source_controller #(.BOR_HOLD(20)) DUT (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
      .ext_rst_n(ext_rst_n), .por_det(por_det), .bor_det(bor_det), .wdt_expire2(wdt_expire2),
      .wdt_rst_en(wdt_rst_en), .reg_fault(reg_fault), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .core_rst(core_rst), .tap_rst(tap_rst),
      .tap_pin_cfg_rst(tap_pin_cfg_rst), .periph_rst_all(periph_rst_all), .periph_rst(periph_rst),
      .boot_fetch(boot_fetch), .core_run(core_run));
   always #10 ref_clk = ~ref_clk;
   // ====
   // Monitor: which resets fired and the boot fetch order
   always @(posedge ref_clk)
   begin
      if (por_det === 1'h1 && core_run !== 1'h0)
         por_bad <= 1'h1;
      if (clr)
      begin
         seen <= 4'h0;
         seen_p <= 32'h0;
         bq.delete();
      end
      else
      begin
         seen <= seen | {core_rst, tap_rst, tap_pin_cfg_rst, periph_rst_all};
         seen_p <= seen_p | periph_rst;
         if (boot_fetch != 2'h0 && (bq.size() == 0 || bq[$] != boot_fetch))
            bq.push_back(boot_fetch);
      end
   end
   task automatic tally_and_finish();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] dt, output logic [31:0] v);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= dt;
      avs_write <= wr;
      avs_read <= !wr;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (avs_waitrequest !== 1'h0 && n < 50);
      v = avs_readdata;
      if (n >= 50)
         miscompares++;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask
   task automatic clear();
      @(posedge ref_clk);
      clr <= 1'h1;
      @(posedge ref_clk);
      clr <= 1'h0;
   endtask
   task automatic hold(input int w, input int len);
      clear();
      if (w == 0)
         wdt_expire2 <= 1'h1;
      else if (w == 1)
         reg_fault <= 1'h1;
      else
         bor_det <= 1'h1;
      repeat (len) @(posedge ref_clk);
      wdt_expire2 <= 1'h0;
      reg_fault <= 1'h0;
      bor_det <= 1'h0;
   endtask
   task automatic quiet();
      repeat (30) @(posedge ref_clk);
      cmp(seen, 4'h0);
   endtask
   // Expected domains {core, test port, pin config, peripherals}
   task automatic boot(input logic [3:0] e, input int bit_no);
      int n;
      n = 0;
      while (core_rst !== 1'h1 && n < 300)
      begin
         @(posedge ref_clk);
         n++;
      end
      while (core_run !== 1'h1 && n < 600)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 600)
         miscompares++;
      @(posedge ref_clk);
      cmp(seen, e);
      cmp({bq[0], bq[1], bq[2]}, 32'h1B);
      cause_m = (bit_no == rst_ctrl_pkg::CAUSE_PIN) ? 1 : cause_m | (1 << bit_no);
      bus(1'h0, rst_ctrl_pkg::ADDR_CAUSE, 32'h0, q);
      cmp(q, cause_m);
   endtask
   initial
   begin
      #200000;
      miscompares++;
      tally_and_finish();
   end
   // ====
   // Main sequence
   initial
   begin
      rstn <= 1'h0;
      void'($urandom(32'hF9ED));
      cause_m = 0;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'h1;
      boot(4'hF, rst_ctrl_pkg::CAUSE_POR);
      cmp(por_bad, 1'h0);
      bus(1'h0, rst_ctrl_pkg::ADDR_SUPPLY, 32'h0, q);
      cmp(q, 32'h0);
      bus(1'h0, 4'hF, 32'h0, q);
      cmp(q, 32'h0);
      clear();
      press <= 1'h1;
      @(posedge ref_clk);
      press <= 1'h0;
      boot(4'hB, rst_ctrl_pkg::CAUSE_PIN);
      clear();
      bus(1'h1, rst_ctrl_pkg::ADDR_CORE, 32'h1 << rst_ctrl_pkg::CORE_SYSREQ, q);
      boot(4'h9, rst_ctrl_pkg::CAUSE_SW);
      hold(0, 1);
      quiet();
      wdt_rst_en <= 1'h1;
      hold(0, 1);
      boot(4'h9, rst_ctrl_pkg::CAUSE_WDT);
      hold(1, 30);
      quiet();
      bus(1'h1, rst_ctrl_pkg::ADDR_SUPPLY, 32'h4, q);
      hold(1, 3);
      boot(4'h9, rst_ctrl_pkg::CAUSE_REG);
      bus(1'h1, rst_ctrl_pkg::ADDR_SUPPLY, 32'h0, q);
      hold(2, 10);
      quiet();
      bus(1'h1, rst_ctrl_pkg::ADDR_SUPPLY, 32'h1, q);
      hold(2, 4);
      boot(4'h9, rst_ctrl_pkg::CAUSE_BOR);
      repeat (30) @(posedge ref_clk);
      bus(1'h0, rst_ctrl_pkg::ADDR_STATUS, 32'h0, q);
      cmp(q[2], 1'h0);
      bus(1'h1, rst_ctrl_pkg::ADDR_CAUSE, 32'h3F, q);
      cause_m = 0;
      d = 8 + $urandom % 8;
      bus(1'h1, rst_ctrl_pkg::ADDR_SUPPLY, (d << 8) | 2, q);
      hold(2, 2);
      quiet();
      hold(2, d + 6);
      boot(4'h9, rst_ctrl_pkg::CAUSE_BOR);
      k = $urandom % 32;
      clear();
      bus(1'h1, rst_ctrl_pkg::ADDR_PERIPH, 32'h1 << k, q);
      bus(1'h1, rst_ctrl_pkg::ADDR_PERIPH, 32'h0, q);
      repeat (4) @(posedge ref_clk);
      cmp(seen_p, 32'h1 << k);
      cmp(seen, 4'h0);
      tally_and_finish();
   end
endmodule // reset_source_controller_bench
